// >>> include/dsss_cfg.svh
// dsss_cfg.svh: constants of the dual supply switch sequencer
`ifndef DSSS_CFG_SVH
`define DSSS_CFG_SVH

// ---------------------------------------------------------------
// clock and time units
// ---------------------------------------------------------------
`define DSSS_CLK_NS     100
`define DSSS_NS_US      1000
`define DSSS_NS_MS      1000000
`define DSSS_NS_S       1000000000
// least time in whole cycles, rounded up
`define DSSS_CYC(t, u) (32'((64'(t) * 64'(u) + 64'(`DSSS_CLK_NS) - 64'd1) / 64'(`DSSS_CLK_NS)))

// ---------------------------------------------------------------
// documented delays, in their own units
// ---------------------------------------------------------------
`define DSSS_T_CB_MS    5
`define DSSS_T_BLANK_MS 5
`define DSSS_T_POR_MS   160
`define DSSS_T_DEB_MS   10
`define DSSS_T_COOL_S   4
`define DSSS_T_OCF_US   100
`define DSSS_T_UV_US    8
`define DSSS_CNT_W      26

// ---------------------------------------------------------------
// register map
// ---------------------------------------------------------------
`define DSSS_AW          12
`define DSSS_A_CTRL      12'h000
`define DSSS_A_STAT      12'h004
`define DSSS_HSIZE_WORD  3'h2
`define DSSS_CTRL_RETRY  0
`define DSSS_CTRL_RST    1'b0
`define DSSS_ST_FLT      0
`define DSSS_ST_ON       2
`define DSSS_ST_POR      4
`define DSSS_ST_PIN      5

`endif

// >>> include/dsss_pkg.sv
// dsss_pkg.sv: types shared by the supply switch sequencer
`include "dsss_cfg.svh"
package dsss_pkg;
  typedef logic [`DSSS_CNT_W-1:0] dsss_cnt_t;
  typedef enum logic [2:0] {
    DSSS_IDLE, DSSS_DEB, DSSS_BLANK, DSSS_RUN, DSSS_TRIP
  } dsss_chst_e;
  // synchronised pin inputs
  typedef struct packed {
    logic       hv;
    logic [1:0] en_n;
    logic [1:0] sup;
    logic [1:0] lim;
    logic [1:0] shrt;
  } dsss_in_s;
  typedef struct packed {
    dsss_chst_e st;
    dsss_cnt_t  tmr;
    dsss_cnt_t  ocf;
    dsss_cnt_t  uvc;
    logic       en_q;
  } dsss_chan_s;
  typedef struct packed {
    dsss_in_s   meta;
    dsss_in_s   syn;
    dsss_cnt_t  por_cnt;
    logic       por_done;
    logic       retry;
    logic       a_wr;
    logic [31:0] rdata;
    logic       rdy;
    logic       rsp;
    logic [1:0] chg;
    logic [1:0] dis;
    logic [1:0] fast;
    logic       flt_oe;
    logic       flt_o;
  } dsss_top_s;
endpackage : dsss_pkg

// >>> logic/dsss_chan.sv
// dsss_chan.sv: one supply channel: debounce, gate drive, breaker
`timescale 1ns/1ns
`include "dsss_cfg.svh"
module dsss_chan
  import dsss_pkg::*;
#(
  parameter int P_DEB   = 100000,
  parameter int P_BLANK = 50000,
  parameter int P_CB    = 50000,
  parameter int P_COOL  = 40000000,
  parameter int P_OCF   = 1000,
  parameter int P_UV    = 80
)(
  input  wire logic i_clk,
  input  wire logic i_arst_n,
  input  wire logic i_run,
  input  wire logic i_retry,
  input  wire logic i_en_n,
  input  wire logic i_sup_ok,
  input  wire logic i_limit,
  input  wire logic i_short,
  output logic      o_charge,
  output logic      o_dis,
  output logic      o_fast,
  output logic      o_fault,
  output logic      o_on
);
  localparam dsss_cnt_t L_DEB   = dsss_cnt_t'(P_DEB - 1);
  localparam dsss_cnt_t L_BLANK = dsss_cnt_t'(P_BLANK - 1);
  localparam dsss_cnt_t L_CB    = dsss_cnt_t'(P_CB - P_OCF - 1);
  localparam dsss_cnt_t L_COOL  = dsss_cnt_t'(P_COOL - 1);
  localparam dsss_cnt_t L_OCF   = dsss_cnt_t'(P_OCF);
  localparam dsss_cnt_t L_UV    = dsss_cnt_t'(P_UV);
  localparam dsss_chan_s L_RST  = '{st: DSSS_IDLE, tmr: '0, ocf: '0,
                                    uvc: '0, en_q: 1'b1};

  dsss_chan_s s_r;
  dsss_chan_s s_nxt;
  logic       uv;
  logic       oc_hit;
  logic       en_rise;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    s_nxt   = s_r;
    s_nxt.en_q = i_en_n;
    en_rise = i_en_n & ~s_r.en_q;
    uv      = (s_r.uvc >= L_UV);
    oc_hit  = i_limit && (s_r.ocf >= L_OCF);
    // supply low must persist before it counts
    if (i_sup_ok)
      s_nxt.uvc = '0;
    else if (!uv)
      s_nxt.uvc = s_r.uvc + 1'b1;
    // short limiting blips in run never reach the breaker; at the end of blanking any limit trips it
    if (!i_limit || s_r.st != DSSS_RUN)
      s_nxt.ocf = '0;
    else if (!oc_hit)
      s_nxt.ocf = s_r.ocf + 1'b1;
    case (s_r.st)
      DSSS_IDLE:
      begin
        s_nxt.tmr = '0;
        if (i_run && i_sup_ok && !i_en_n)
          s_nxt.st = DSSS_DEB;
      end
      DSSS_DEB:
      begin
        if (!i_sup_ok || i_en_n)
          s_nxt.st = DSSS_IDLE;
        else if (s_r.tmr == L_DEB)
        begin
          s_nxt.st  = DSSS_BLANK;
          s_nxt.tmr = '0;
        end
        else
          s_nxt.tmr = s_r.tmr + 1'b1;
      end
      DSSS_BLANK:
      begin
        // breaker may only act once blanking ends
        if (s_r.tmr == L_BLANK)
        begin
          s_nxt.st  = i_limit ? DSSS_TRIP : DSSS_RUN;
          s_nxt.tmr = '0;
        end
        else
          s_nxt.tmr = s_r.tmr + 1'b1;
      end
      DSSS_RUN:
      begin
        if (!oc_hit)
          s_nxt.tmr = '0;
        else if (s_r.tmr == L_CB)
        begin
          s_nxt.st  = DSSS_TRIP;
          s_nxt.tmr = '0;
        end
        else
          s_nxt.tmr = s_r.tmr + 1'b1;
      end
      DSSS_TRIP:
      begin
        // latch-off holds here; retry waits out the cool-down
        if (!i_retry)
          s_nxt.tmr = '0;
        else if (s_r.tmr == L_COOL)
        begin
          s_nxt.st  = DSSS_IDLE;
          s_nxt.tmr = '0;
        end
        else
          s_nxt.tmr = s_r.tmr + 1'b1;
      end
      default:
        s_nxt.st = DSSS_IDLE;
    endcase
    // enable high or supply loss turns off and clears the fault
    if (en_rise || uv)
    begin
      s_nxt.st  = DSSS_IDLE;
      s_nxt.tmr = '0;
    end
    if (!i_run)
    begin
      s_nxt.st  = DSSS_IDLE;
      s_nxt.tmr = '0;
      s_nxt.ocf = '0;
      s_nxt.uvc = '0;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      s_r <= L_RST;
    else
      s_r <= s_nxt;
  end

  // drive mode: charge, fast pull-down on short, else discharge
  assign o_on     = (s_r.st == DSSS_BLANK) || (s_r.st == DSSS_RUN);
  assign o_charge = o_on & ~i_short;
  assign o_fast   = o_on & i_short;
  assign o_dis    = ~o_on;
  assign o_fault  = (s_r.st == DSSS_TRIP);

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  sequence s_run_to_trip;
    s_r.st == DSSS_RUN ##1 s_r.st == DSSS_TRIP;
  endsequence
  sequence s_deb_done;
    s_r.st == DSSS_DEB && s_r.tmr == L_DEB && i_sup_ok && !i_en_n
      && i_run && !uv && !en_rise;
  endsequence
  sequence s_oc_blip;
    s_r.st == DSSS_RUN && !i_limit ##1 i_limit [*2] ##1 !i_limit;
  endsequence

  chk_brk_trip: assert property (
    s_run_to_trip |-> $past(s_r.tmr) == L_CB && $past(oc_hit))
    else $error("breaker tripped at the wrong count");
  chk_charge_on: assert property (
    s_deb_done |=> s_r.st == DSSS_BLANK && (o_charge || o_fast))
    else $error("gate not charged after debounce");
  chk_blank_hold: assert property (
    s_r.st == DSSS_BLANK && s_r.tmr != L_BLANK |=> s_r.st != DSSS_TRIP)
    else $error("breaker latched during blanking");
  chk_off_dis: assert property (
    !o_on |-> o_dis && !o_charge && !o_fast)
    else $error("off channel not discharging");
  chk_en_clear: assert property (
    i_en_n && !s_r.en_q |=> s_r.st == DSSS_IDLE && !o_fault)
    else $error("enable rise did not clear fault");
  chk_deb_abort: assert property (
    s_r.st == DSSS_DEB && (i_en_n || !i_sup_ok) |=> s_r.st == DSSS_IDLE)
    else $error("debounce not abandoned");
  chk_uv_off: assert property (
    !i_sup_ok [*8] ##1 uv |=> s_r.st == DSSS_IDLE)
    else $error("undervoltage did not turn channel off");
  chk_oc_blip: assert property (
    s_oc_blip |=> s_r.ocf == '0 && s_r.tmr == '0)
    else $error("brief overcurrent reached the breaker");
  chk_latch_hold: assert property (
    s_r.st == DSSS_TRIP && !i_retry && !en_rise && !uv && i_run
      |=> s_r.st == DSSS_TRIP)
    else $error("latched fault released by itself");
endmodule : dsss_chan

// >>> logic/dsss_top.sv
// dsss_top.sv: dual supply switch sequencer with AHB-Lite registers
//
// The address map and the AHB-Lite register port were left to the implementer.
`timescale 1ns/1ns
`include "dsss_cfg.svh"
module dsss_top
  import dsss_pkg::*;
#(
  parameter int P_POR_CYC   = `DSSS_CYC(`DSSS_T_POR_MS, `DSSS_NS_MS),
  parameter int P_DEB_CYC   = `DSSS_CYC(`DSSS_T_DEB_MS, `DSSS_NS_MS),
  parameter int P_BLANK_CYC = `DSSS_CYC(`DSSS_T_BLANK_MS, `DSSS_NS_MS),
  parameter int P_CB_CYC    = `DSSS_CYC(`DSSS_T_CB_MS, `DSSS_NS_MS),
  parameter int P_COOL_CYC  = `DSSS_CYC(`DSSS_T_COOL_S, `DSSS_NS_S)
)(
  input  wire logic        i_clk,
  input  wire logic        i_arst_n,
  // AHB-Lite slave
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic        i_hready,
  input  wire logic [31:0] i_hwdata,
  output logic      [31:0] o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  // supply comparators and enables
  input  wire logic        i_hv_supply_good,
  input  wire logic        i_chan1_supply_ok,
  input  wire logic        i_chan2_supply_ok,
  input  wire logic        i_chan1_enable_n,
  input  wire logic        i_chan2_enable_n,
  input  wire logic        i_chan1_current_limit_amp,
  input  wire logic        i_chan2_current_limit_amp,
  input  wire logic        i_chan1_severe_short,
  input  wire logic        i_chan2_severe_short,
  // gate drive mode selects
  output logic             o_chan1_switch_drive_chg,
  output logic             o_chan1_switch_drive_dis,
  output logic             o_chan1_switch_drive_fast,
  output logic             o_chan2_switch_drive_chg,
  output logic             o_chan2_switch_drive_dis,
  output logic             o_chan2_switch_drive_fast,
  // shared open-drain fault line
  input  wire logic        i_fault_n,
  output logic             o_fault_n,
  output logic             o_fault_n_oe
);
  // filter lengths stay fixed; only the long timers are worth shortening
  localparam int P_OCF_CYC = `DSSS_CYC(`DSSS_T_OCF_US, `DSSS_NS_US);
  localparam int P_UV_CYC  = `DSSS_CYC(`DSSS_T_UV_US, `DSSS_NS_US);
  localparam dsss_cnt_t L_POR = dsss_cnt_t'(P_POR_CYC - 1);
  localparam int L_MAX = (1 << `DSSS_CNT_W) - 1;

  // ---------------------------------------------------------------
  // parameter check
  // ---------------------------------------------------------------
  generate
    if (P_CB_CYC <= P_OCF_CYC || P_POR_CYC < 1 || P_DEB_CYC < 1
        || P_BLANK_CYC < 1 || P_COOL_CYC < 1 || P_POR_CYC > L_MAX
        || P_DEB_CYC > L_MAX || P_BLANK_CYC > L_MAX
        || P_CB_CYC > L_MAX || P_COOL_CYC > L_MAX)
    begin : g_bad_param
      $error("dsss_top: timing parameter out of range");
    end
  endgenerate

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  // returns {status hit, control hit}
  // shared by the read mux and the write strobe
  function automatic logic [1:0] dsss_dec(
    input logic [`DSSS_AW-1:0] a
  );
    logic [1:0] hit;
    hit    = 2'b00;
    hit[0] = (a == `DSSS_A_CTRL);
    hit[1] = (a == `DSSS_A_STAT);
    return hit;
  endfunction : dsss_dec

  dsss_top_s  s_r;
  dsss_top_s  s_nxt;
  dsss_in_s   pins;
  logic [1:0] ch_chg;
  logic [1:0] ch_dis;
  logic [1:0] ch_fast;
  logic [1:0] ch_flt;
  logic [1:0] ch_on;
  logic [1:0] dec;
  logic       acc;

  // raw pins gathered for the synchroniser
  assign pins.hv   = i_hv_supply_good;
  assign pins.en_n = {i_chan2_enable_n, i_chan1_enable_n};
  assign pins.sup  = {i_chan2_supply_ok, i_chan1_supply_ok};
  assign pins.lim  = {i_chan2_current_limit_amp,
                      i_chan1_current_limit_amp};
  assign pins.shrt = {i_chan2_severe_short, i_chan1_severe_short};

  // ---------------------------------------------------------------
  // channel controllers
  // ---------------------------------------------------------------
  // one instance each, sharing only run and retry, never state
  generate
    for (genvar g = 0; g < 2; g++)
    begin : g_chan
      dsss_chan #(
        .P_DEB   (P_DEB_CYC),
        .P_BLANK (P_BLANK_CYC),
        .P_CB    (P_CB_CYC),
        .P_COOL  (P_COOL_CYC),
        .P_OCF   (P_OCF_CYC),
        .P_UV    (P_UV_CYC)
      ) u_chan (
        .i_clk    (i_clk),
        .i_arst_n (i_arst_n),
        .i_run    (s_r.por_done),
        .i_retry  (s_r.retry),
        .i_en_n   (s_r.syn.en_n[g]),
        .i_sup_ok (s_r.syn.sup[g]),
        .i_limit  (s_r.syn.lim[g]),
        .i_short  (s_r.syn.shrt[g]),
        .o_charge (ch_chg[g]),
        .o_dis    (ch_dis[g]),
        .o_fast   (ch_fast[g]),
        .o_fault  (ch_flt[g]),
        .o_on     (ch_on[g])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    s_nxt = s_r;
    // two-stage synchroniser; meta is read only by syn
    s_nxt.meta = pins;
    s_nxt.syn  = s_r.meta;
    // power-on delay restarts on any loss of the high supply
    if (!s_r.syn.hv)
    begin
      s_nxt.por_cnt  = '0;
      s_nxt.por_done = 1'b0;
    end
    else if (!s_r.por_done)
    begin
      if (s_r.por_cnt == L_POR)
        s_nxt.por_done = 1'b1;
      else
        s_nxt.por_cnt = s_r.por_cnt + 1'b1;
    end
    // bus: zero wait states, always OKAY
    s_nxt.rdy = 1'b1;
    s_nxt.rsp = 1'b0;
    acc = i_hsel & i_htrans[1] & i_hready;
    dec = dsss_dec(i_haddr[`DSSS_AW-1:0]);
    // narrow writes are dropped so the variant bit cannot half-land
    s_nxt.a_wr = acc & i_hwrite & dec[0]
               & (i_hsize == `DSSS_HSIZE_WORD);
    s_nxt.rdata = '0;
    if (acc && !i_hwrite && dec[0])
      s_nxt.rdata[`DSSS_CTRL_RETRY] = s_r.retry;
    else if (acc && !i_hwrite && dec[1])
    begin
      s_nxt.rdata[`DSSS_ST_FLT +: 2] = ch_flt;
      s_nxt.rdata[`DSSS_ST_ON +: 2]  = ch_on;
      s_nxt.rdata[`DSSS_ST_POR]      = s_r.por_done;
      s_nxt.rdata[`DSSS_ST_PIN]      = i_fault_n;
    end
    // data phase of a control write selects the variant
    // a change of variant takes effect at once, also on a channel already tripped
    if (s_r.a_wr)
      s_nxt.retry = i_hwdata[`DSSS_CTRL_RETRY];
    // drive selects and fault line, registered to the pins
    s_nxt.chg    = ch_chg;
    s_nxt.dis    = ch_dis;
    s_nxt.fast   = ch_fast;
    s_nxt.flt_oe = |ch_flt;
    s_nxt.flt_o  = 1'b0;
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      s_r          <= '0;
      s_r.retry    <= `DSSS_CTRL_RST;
      s_r.rdy      <= 1'b1;
      s_r.dis      <= 2'b11;
      // enables idle high, so no false edge follows reset
      s_r.meta.en_n <= 2'b11;
      s_r.syn.en_n  <= 2'b11;
    end
    else
      s_r <= s_nxt;
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign o_hrdata                  = s_r.rdata;
  assign o_hreadyout               = s_r.rdy;
  assign o_hresp                   = s_r.rsp;
  assign o_chan1_switch_drive_chg  = s_r.chg[0];
  assign o_chan1_switch_drive_dis  = s_r.dis[0];
  assign o_chan1_switch_drive_fast = s_r.fast[0];
  assign o_chan2_switch_drive_chg  = s_r.chg[1];
  assign o_chan2_switch_drive_dis  = s_r.dis[1];
  assign o_chan2_switch_drive_fast = s_r.fast[1];
  // open drain: only ever pulls low, enable marks the pull
  assign o_fault_n                 = s_r.flt_o;
  assign o_fault_n_oe              = s_r.flt_oe;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  // every check runs in the one clock domain
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  sequence s_hv_lost;
    !s_r.syn.hv ##1 !s_r.syn.hv;
  endsequence
  sequence s_ctrl_wr;
    i_hsel && i_htrans[1] && i_hready && i_hwrite
      && i_haddr[`DSSS_AW-1:0] == `DSSS_A_CTRL
      && i_hsize == `DSSS_HSIZE_WORD;
  endsequence
  sequence s_rd_acc;
    i_hsel && i_htrans[1] && i_hready && !i_hwrite;
  endsequence

  chk_por_hold: assert property (
    !s_r.por_done [*3]
      |-> !o_chan1_switch_drive_chg && !o_chan2_switch_drive_chg)
    else $error("channel charged before power-on delay");
  chk_por_time: assert property (
    $rose(s_r.por_done) |-> $past(s_r.por_cnt) == L_POR
      && $past(s_r.syn.hv))
    else $error("power-on delay length wrong");
  chk_fast_short: assert property (
    s_r.syn.shrt[0] && ch_on[0]
      |=> o_chan1_switch_drive_fast && !o_chan1_switch_drive_chg)
    else $error("fast discharge not selected on short");
  chk_fault_pin: assert property (
    ##1 o_fault_n_oe == $past(|ch_flt) && !o_fault_n)
    else $error("fault line does not follow breaker");
  chk_glob_clear: assert property (
    s_hv_lost |-> ##1 ch_flt == 2'b00 ##1 !o_fault_n_oe)
    else $error("high supply loss left a fault latched");
  chk_retry_wr: assert property (
    s_ctrl_wr ##1 1'b1
      |=> s_r.retry == $past(i_hwdata[`DSSS_CTRL_RETRY]))
    else $error("control write did not set variant");
  chk_drive_excl: assert property (
    ##1 (o_chan2_switch_drive_dis ^ (o_chan2_switch_drive_chg
      || o_chan2_switch_drive_fast)))
    else $error("drive modes not exclusive");
  // reads return the state seen in the address phase
  chk_stat_flt: assert property (
    s_rd_acc ##0 dec[1] |=> o_hrdata[`DSSS_ST_FLT +: 2] == $past(ch_flt))
    else $error("status read lost a fault flag");
  chk_stat_por: assert property (
    s_rd_acc ##0 dec[1]
      |=> o_hrdata[`DSSS_ST_POR] == $past(s_r.por_done))
    else $error("status read lost power-on state");
  chk_ctrl_rd: assert property (
    s_rd_acc ##0 dec[0]
      |=> o_hrdata == (32'($past(s_r.retry)) << `DSSS_CTRL_RETRY))
    else $error("control read wrong");
  // both drives must be off three cycles after the synchronised high supply goes
  chk_hv_off: assert property (
    s_hv_lost ##1 1'b1
      |=> !o_chan1_switch_drive_chg && !o_chan2_switch_drive_chg)
    else $error("high supply loss left a channel on");
endmodule : dsss_top

// >>> test/dsss_far.sv
// dsss_far.sv: pass transistors and fault wire beyond the sequencer
`timescale 1ns/1ns
module dsss_far (
  input  wire logic [1:0] i_chg,
  input  wire logic [1:0] i_overload,
  input  wire logic       i_fault_n,
  input  wire logic       i_fault_n_oe,
  output logic      [1:0] o_limit,
  output logic            o_fault_wire
);
  // ---------------------------------------------------------------
  // load and wire behaviour
  // ---------------------------------------------------------------
  // a transistor limits only while its gate is charged into a heavy load
  assign o_limit      = i_chg & i_overload;
  // pull-up resistor holds the wire high unless the device pulls it
  assign o_fault_wire = i_fault_n_oe ? i_fault_n : 1'b1;
endmodule : dsss_far

// >>> test/tb_dual_supply_switch_sequencer.sv
// tb_dual_supply_switch_sequencer.sv: scenario bench of the sequencer
`timescale 1ns/1ns
module tb_dual_supply_switch_sequencer
  import dsss_pkg::*;
;
  // ---------------------------------------------------------------
  // shortened timer counts and bench signals
  // ---------------------------------------------------------------
  localparam int POR = 50, DEB = 20, BLK = 20, CB = 1100, COOL = 40;
  logic        clk, arst_n, hsel, hwrite, hrdy, hresp, hv, flt_w;
  logic        flt_n, flt_oe;
  logic [1:0]  htrans, sup, en_n, sev, ovl, lim, chg, dis, fast;
  logic [2:0]  hsize;
  logic [7:0]  mon;
  logic [31:0] haddr, hwdata, hrdata, rd;
  int          failures, samples_checked, cyc, n;

  assign mon = {flt_oe, flt_oe, fast, dis, chg};

  dsss_top #(.P_POR_CYC(POR), .P_DEB_CYC(DEB), .P_BLANK_CYC(BLK),
    .P_CB_CYC(CB), .P_COOL_CYC(COOL)) dut (
    .i_clk(clk), .i_arst_n(arst_n), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
    .i_hready(hrdy), .i_hwdata(hwdata), .o_hrdata(hrdata),
    .o_hreadyout(hrdy), .o_hresp(hresp), .i_hv_supply_good(hv),
    .i_chan1_supply_ok(sup[0]), .i_chan2_supply_ok(sup[1]),
    .i_chan1_enable_n(en_n[0]), .i_chan2_enable_n(en_n[1]),
    .i_chan1_current_limit_amp(lim[0]),
    .i_chan2_current_limit_amp(lim[1]),
    .i_chan1_severe_short(sev[0]), .i_chan2_severe_short(sev[1]),
    .o_chan1_switch_drive_chg(chg[0]), .o_chan1_switch_drive_dis(dis[0]),
    .o_chan1_switch_drive_fast(fast[0]),
    .o_chan2_switch_drive_chg(chg[1]), .o_chan2_switch_drive_dis(dis[1]),
    .o_chan2_switch_drive_fast(fast[1]), .i_fault_n(flt_w),
    .o_fault_n(flt_n), .o_fault_n_oe(flt_oe));

  dsss_far far (.i_chg(chg), .i_overload(ovl), .i_fault_n(flt_n),
    .i_fault_n_oe(flt_oe), .o_limit(lim), .o_fault_wire(flt_w));

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // count edges until a monitored output is high; kind 0 chg 1 dis
  // 2 fast 3 fault pull; outputs are read before the edge updates land
  task automatic wait_hi(int k, int c, int lmt);
    n = 0;
    while (mon[2*k+c] !== 1'b1 && n < lmt)
    begin
      @(posedge clk);
      n++;
    end
  endtask : wait_hi

  task automatic inrange(string what, int lo, int hi);
    check(what, 32'(n >= lo && n <= hi), 32'h1);
  endtask : inrange

  task automatic tick(int k);
    repeat (k) @(posedge clk);
  endtask : tick

  // single word transfer; waits for ready in both phases
  task automatic ahb(logic wr, logic [31:0] a, logic [31:0] wd);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= wr;
    htrans <= 2'b10;
    do @(posedge clk); while (hrdy !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk); while (hrdy !== 1'b1);
    rd = hrdata;
    check("bus response", hresp, 32'h0);
  endtask : ahb

  task automatic end_sim();
    if (failures == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_power_up();
    ahb(1'b0, 32'h0, 32'h0);
    check("control reset", rd, 32'h0);
    ahb(1'b1, 32'h10, 32'h1);
    ahb(1'b0, 32'h10, 32'h0);
    check("unmapped read", rd, 32'h0);
    hsize <= 3'h0;
    ahb(1'b1, 32'h0, 32'h1);
    hsize <= 3'h2;
    ahb(1'b0, 32'h0, 32'h0);
    check("narrow write", rd, 32'h0);
    ahb(1'b0, 32'h4, 32'h0);
    check("status idle", rd, 32'h20);
    tick(100);
    check("no high supply", chg, 2'b00);
    @(posedge clk) hv <= 1'b1;
    wait_hi(0, 0, 200);
    inrange("power on delay", POR + DEB, POR + DEB + 12);
    check("charge drive", {chg[0], dis[0], fast[0]}, 3'b100);
    check("low chan waits", chg[1], 1'b0);
    @(posedge clk) sup[1] <= 1'b1;
    wait_hi(0, 1, 100);
    inrange("debounce", DEB, DEB + 10);
  endtask : t_power_up

  task automatic t_deb_restart();
    @(posedge clk) en_n[0] <= 1'b1;
    wait_hi(1, 0, 10);
    inrange("off delay", 1, 6);
    check("off drive", {chg[0], dis[0], fast[0]}, 3'b010);
    check("other chan", chg[1], 1'b1);
    tick(250);
    @(posedge clk) en_n[0] <= 1'b0;
    tick(12);
    @(posedge clk) en_n[0] <= 1'b1;
    tick(4);
    @(posedge clk) en_n[0] <= 1'b0;
    wait_hi(0, 0, 100);
    inrange("debounce restart", DEB, DEB + 10);
  endtask : t_deb_restart

  task automatic t_trip();
    tick(40);
    // two-cycle blip, far too short for the breaker
    @(posedge clk) ovl[0] <= 1'b1;
    tick(1);
    @(posedge clk) ovl[0] <= 1'b0;
    tick(4);
    @(posedge clk) ovl[0] <= 1'b1;
    tick(500);
    @(posedge clk) ovl[0] <= 1'b0;
    tick(5);
    check("brief overload", flt_oe, 1'b0);
    @(posedge clk) ovl[0] <= 1'b1;
    wait_hi(3, 0, 2000);
    inrange("breaker delay", CB, CB + 12);
    @(posedge clk) ovl[0] <= 1'b0;
    tick(3);
    check("trip drive", {chg[0], dis[0], flt_w}, 3'b010);
    check("other chan", chg[1], 1'b1);
    ahb(1'b0, 32'h4, 32'h0);
    check("status fault", rd, 32'h19);
    tick(50);
    check("latched off", chg[0], 1'b0);
    @(posedge clk) en_n[0] <= 1'b1;
    tick(250);
    check("fault reset", {flt_oe, flt_w}, 2'b01);
    @(posedge clk) en_n[0] <= 1'b0;
    wait_hi(0, 0, 100);
    inrange("on after reset", DEB, DEB + 10);
  endtask : t_trip

  task automatic t_uv();
    tick(40);
    @(posedge clk) sup[0] <= 1'b0;
    tick(60);
    check("uv filter", chg[0], 1'b1);
    wait_hi(1, 0, 60);
    inrange("uv delay", 15, 35);
    check("uv drive", {chg[0], dis[0]}, 2'b01);
    @(posedge clk) sup[0] <= 1'b1;
    wait_hi(0, 0, 100);
    inrange("uv recovery", DEB, DEB + 10);
  endtask : t_uv

  task automatic t_retry();
    ahb(1'b1, 32'h0, 32'h1);
    ahb(1'b0, 32'h0, 32'h0);
    check("control retry", rd, 32'h1);
    tick(40);
    @(posedge clk) ovl[0] <= 1'b1;
    wait_hi(3, 0, 2000);
    @(posedge clk) ovl[0] <= 1'b0;
    wait_hi(0, 0, 300);
    inrange("retry delay", COOL + DEB - 5, COOL + DEB + 15);
    check("retry clears", flt_oe, 1'b0);
    // overload through start-up trips as blanking ends
    @(posedge clk) ovl[0] <= 1'b1;
    wait_hi(3, 0, 60);
    inrange("blank trip", BLK - 5, BLK + 5);
    @(posedge clk) ovl[0] <= 1'b0;
    wait_hi(0, 0, 200);
    inrange("retry again", COOL + DEB - 5, COOL + DEB + 15);
  endtask : t_retry

  task automatic t_hv_loss();
    @(posedge clk) ovl[1] <= 1'b1;
    wait_hi(3, 1, 2000);
    @(posedge clk) hv <= 1'b0;
    ovl[1] <= 1'b0;
    tick(6);
    check("hv loss", {flt_oe, chg, dis}, 5'b00011);
    @(posedge clk) hv <= 1'b1;
    wait_hi(0, 1, 200);
    inrange("por again", POR + DEB, POR + DEB + 12);
  endtask : t_hv_loss

  task automatic t_short();
    @(posedge clk) sev <= 2'b11;
    wait_hi(2, 1, 10);
    inrange("fast delay", 1, 4);
    check("fast drive", {chg[1], dis[1], fast[1]}, 3'b001);
    check("fast drive one", {chg[0], dis[0], fast[0]}, 3'b001);
    @(posedge clk) sev <= 2'b00;
  endtask : t_short

  // ---------------------------------------------------------------
  // clock, timeout and main sequence
  // ---------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // a hung wait ends the run as a failure
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      failures++;
      end_sim();
    end
  end

  initial
  begin
    arst_n = 1'b0;
    hsel   = 1'b0;
    haddr  = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0;
    hv     = 1'b0;
    sup    = 2'b01;
    en_n   = 2'b00;
    sev    = 2'b00;
    ovl    = 2'b00;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    t_power_up();
    t_deb_restart();
    t_trip();
    t_uv();
    t_retry();
    t_hv_loss();
    t_short();
    end_sim();
  end
endmodule : tb_dual_supply_switch_sequencer
